// >>> logic/smcf_pkg.sv
`default_nettype none
package smcf_pkg;

   // ======================================================================
   // Register map (byte addresses)
   // ======================================================================
   localparam logic [7:0] SMCF_CTRL_OFF = 8'h00;
   localparam logic [7:0] SMCF_LEN_OFF  = 8'h04;
   localparam logic [7:0] SMCF_MPOS_OFF = 8'h08;
   localparam logic [7:0] SMCF_XOFF_OFF = 8'h0C;
   localparam logic [7:0] SMCF_EXTF_OFF = 8'h10;
   localparam logic [7:0] SMCF_STAT_OFF = 8'h14;
   localparam logic [7:0] SMCF_PT_OFF   = 8'h18;

   // ======================================================================
   // Control field positions
   // ======================================================================
   localparam int SMCF_B_MK_EN   = 0;
   localparam int SMCF_B_MK_SRC  = 1;
   localparam int SMCF_B_MK_SHP  = 2;
   localparam int SMCF_B_COMMON  = 3;
   localparam int SMCF_B_RUN1    = 4;
   localparam int SMCF_B_TRG_EXT = 6;
   localparam int SMCF_B_FN_ARB  = 7;
   localparam int SMCF_B_P1_EXT  = 8;
   localparam int SMCF_B_P2_EXT  = 9;
   localparam int SMCF_B_DIV     = 12;
   localparam int SMCF_B_RUN2    = 16;

   // ======================================================================
   // Reset values and marker geometry
   // ======================================================================
   localparam logic [31:0] SMCF_CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] SMCF_LEN_RST  = 16'h0040;
   localparam logic [15:0] SMCF_MPOS_RST = 16'h0000;
   localparam logic [15:0] SMCF_XOFF_RST = 16'h0000;
   localparam logic [31:0] SMCF_EXTF_RST = 32'h0000_0000;
   localparam int          SMCF_PULSE_PTS = 16;
   localparam int          SMCF_POS_STEP  = 32;
   localparam int          SMCF_WC_PTS    = 16;
   localparam logic [3:0]  SMCF_DIV_MAX   = 4'h8;

   typedef enum logic [1:0] {
      SMCF_CONT,
      SMCF_TRIG,
      SMCF_GATE
   } smcf_run_t;

endpackage : smcf_pkg
`default_nettype wire

// >>> logic/smcf_div.sv
`timescale 1ns/1ps
`default_nettype none
module smcf_div
   import smcf_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       tick_in,
   input  wire logic [3:0] exp_sel,
   output logic            tick_out
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [2:0] bit_sel;

   // ======================================================================
   // Binary counter, one bit chosen as the divided clock
   // ======================================================================
   always_comb begin
      cnt_nxt = tick_in ? cnt_r + 8'h01 : cnt_r;
      bit_sel = exp_sel[2:0] - 3'h1;
      if (exp_sel == 4'h0) begin
         tick_out = tick_in;
      end else if (exp_sel == SMCF_DIV_MAX) begin
         // Falling edge of bit 7 of the counter
         tick_out = tick_in & cnt_r[7] & ~cnt_nxt[7];    // R21
      end else begin
         tick_out = tick_in & cnt_r[bit_sel] & ~cnt_nxt[bit_sel]; // R21
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   div_step_a: assert property (@(posedge mclk) disable iff (rst) // R19
      tick_out |-> tick_in)
      else $error("divided tick without source tick");

endmodule : smcf_div
`default_nettype wire

// >>> logic/smcf_top.sv
// How it works
// R01 - Button acts only with external trigger source
// R02 - Triggered mode: each press plays one waveform
// R03 - Gated mode: play while held, stop on release
// R04 - Marker output off after every reset
// R05 - Marker on lights indicator; off drives low
// R06 - Marker source picks first or second pair
// R07 - Pulse or complete shape; pulse 16 points
// R08 - Waveform-complete marker width and place fixed
// R09 - Pulse position programmable in 32-point steps
// R10 - Pulse defaults to first waveform point
// R11 - Pair shares clock; separate pairs unsynchronised
// R12 - Common feed: one clock, one run mode
// R13 - Common feed blocks second pair clock settings
// R14 - Cross-pair offset editable only in common
// R15 - Signed start offset limited to waveform length
// R16 - External clock only in arbitrary or sequence
// R17 - Frequency setting active once any pair external
// R18 - First pair source change leaves second alone
// R19 - First pair divides external clock by 2^n
// R20 - One external clock input feeds all channels
// R21 - Divider is counter, exponent picks bit
// R22 - Pulse from point counter versus position
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module smcf_top
   import smcf_pkg::*;
#(
   parameter int LEN_W = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        manual_push_button,
   input  wire logic        ext_sample_clock,
   output logic             marker_out,
   output logic             marker_led,
   output logic             pair1_run,
   output logic             pair2_run
);
   initial begin
      if (LEN_W != 16) $error("LEN_W must be 16");
   end

   // ======================================================================
   // Pin synchronisers (three stages, second and third must agree)
   // ======================================================================
   logic [2:0] btn_s_r, clk_s_r;
   logic [2:0] btn_s_nxt, clk_s_nxt;
   logic       btn_r, btn_nxt, eck_r, eck_nxt;

   always_comb begin
      btn_s_nxt = {btn_s_r[1:0], manual_push_button};
      clk_s_nxt = {clk_s_r[1:0], ext_sample_clock};
      btn_nxt   = (btn_s_r[1] == btn_s_r[2]) ? btn_s_r[2] : btn_r;
      eck_nxt   = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : eck_r;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         btn_s_r <= 3'h0;
         clk_s_r <= 3'h0;
         btn_r   <= 1'b0;
         eck_r   <= 1'b0;
      end else begin
         btn_s_r <= btn_s_nxt;
         clk_s_r <= clk_s_nxt;
         btn_r   <= btn_nxt;
         eck_r   <= eck_nxt;
      end
   end

   logic btn_press, ext_tick;
   assign btn_press = btn_nxt & ~btn_r;
   assign ext_tick  = eck_nxt & ~eck_r;

   // ======================================================================
   // APB register file
   // ======================================================================
   logic [31:0] ctrl_r, ctrl_nxt, extf_r, extf_nxt;
   logic [15:0] len_r, len_nxt, mpos_r, mpos_nxt, xoff_r, xoff_nxt;
   logic        wr_en;
   logic [31:0] wctl;
   logic signed [16:0] woff;

   assign wr_en  = psel & penable & pwrite;
   assign pready = 1'b1;
   assign woff   = $signed({pwdata[15], pwdata[15:0]});

   always_comb begin
      ctrl_nxt = ctrl_r;
      len_nxt  = len_r;
      mpos_nxt = mpos_r;
      xoff_nxt = xoff_r;
      extf_nxt = extf_r;
      wctl     = pwdata;
      if (ctrl_r[SMCF_B_COMMON] && wctl[SMCF_B_COMMON]) begin
         // Second pair settings frozen while fed in common
         wctl[SMCF_B_P2_EXT] = ctrl_r[SMCF_B_P2_EXT];    // R13
         wctl[SMCF_B_RUN2+:2] = ctrl_r[SMCF_B_RUN2+:2];  // R13
      end
      // Applied last so a held second-pair source cannot outlive
      // the function mode that allows it
      if (!wctl[SMCF_B_FN_ARB]) begin
         wctl[SMCF_B_P1_EXT] = 1'b0;                     // R16
         wctl[SMCF_B_P2_EXT] = 1'b0;                     // R16
      end
      if (wr_en) begin
         if (paddr == SMCF_CTRL_OFF) begin
            ctrl_nxt = wctl;                             // R18
         end else if (paddr == SMCF_LEN_OFF) begin
            if (pwdata[15:0] != 16'h0000) len_nxt = pwdata[15:0];
         end else if (paddr == SMCF_MPOS_OFF) begin
            mpos_nxt = pwdata[15:0];                     // R09
         end else if (paddr == SMCF_XOFF_OFF) begin
            if (ctrl_r[SMCF_B_COMMON]                    // R14
                && ((woff < 0) ? -woff : woff) < $signed({1'b0, len_r}))
               xoff_nxt = pwdata[15:0];                  // R15
         end else if (paddr == SMCF_EXTF_OFF) begin
            if (ctrl_r[SMCF_B_P1_EXT] | ctrl_r[SMCF_B_P2_EXT])
               extf_nxt = pwdata;                        // R17
         end
      end
      if (ctrl_nxt[SMCF_B_DIV+:4] > SMCF_DIV_MAX)
         ctrl_nxt[SMCF_B_DIV+:4] = SMCF_DIV_MAX;         // R19
      if (ctrl_nxt[SMCF_B_RUN1+:2] == 2'h3) ctrl_nxt[SMCF_B_RUN1+:2] = 2'h0;
      if (ctrl_nxt[SMCF_B_RUN2+:2] == 2'h3) ctrl_nxt[SMCF_B_RUN2+:2] = 2'h0;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= SMCF_CTRL_RST;                        // R04
         len_r  <= SMCF_LEN_RST;
         mpos_r <= SMCF_MPOS_RST;                        // R10
         xoff_r <= SMCF_XOFF_RST;
         extf_r <= SMCF_EXTF_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         len_r  <= len_nxt;
         mpos_r <= mpos_nxt;
         xoff_r <= xoff_nxt;
         extf_r <= extf_nxt;
      end
   end

   // ======================================================================
   // Sample-clock feeds
   // ======================================================================
   logic common, tick1, tick2, div_tick;
   smcf_run_t mode1, mode2;
   assign common = ctrl_r[SMCF_B_COMMON];
   assign mode1  = smcf_run_t'(ctrl_r[SMCF_B_RUN1+:2]);
   assign mode2  = common ? mode1                        // R12
                          : smcf_run_t'(ctrl_r[SMCF_B_RUN2+:2]);

   smcf_div u_div (
      .mclk     (mclk),
      .rst      (rst),
      .tick_in  (ext_tick),                              // R20
      .exp_sel  (ctrl_r[SMCF_B_DIV+:4]),
      .tick_out (div_tick)
   );

   // Internal feed modelled as one point per system clock
   assign tick1 = ctrl_r[SMCF_B_P1_EXT] ? div_tick : 1'b1; // R19
   assign tick2 = common ? tick1                         // R11
                : (ctrl_r[SMCF_B_P2_EXT] ? ext_tick : 1'b1);

   // ======================================================================
   // Run control and point counters
   // ======================================================================
   logic        btn_ok, shot1_r, shot1_nxt, shot2_r, shot2_nxt;
   logic        run1, run2;
   logic [15:0] pt1_r, pt1_nxt, pt2_r, pt2_nxt, last;
   assign btn_ok = ctrl_r[SMCF_B_TRG_EXT];               // R01
   assign last   = len_r - 16'h0001;

   always_comb begin
      shot1_nxt = shot1_r;
      shot2_nxt = shot2_r;
      if (tick1 && pt1_r == last) shot1_nxt = 1'b0;
      if (tick2 && pt2_r == last) shot2_nxt = 1'b0;
      // A press in the closing cycle starts the next waveform
      if (btn_press && btn_ok && mode1 == SMCF_TRIG) shot1_nxt = 1'b1; // R02
      if (btn_press && btn_ok && mode2 == SMCF_TRIG) shot2_nxt = 1'b1; // R02
      case (mode1)
         SMCF_CONT: run1 = 1'b1;
         SMCF_TRIG: run1 = shot1_r;
         SMCF_GATE: run1 = btn_r & btn_ok;               // R03
         default:   run1 = 1'b0;
      endcase
      case (mode2)
         SMCF_CONT: run2 = 1'b1;
         SMCF_TRIG: run2 = shot2_r;
         SMCF_GATE: run2 = btn_r & btn_ok;               // R03
         default:   run2 = 1'b0;
      endcase
      if (!run1) pt1_nxt = 16'h0000;
      else if (tick1) pt1_nxt = (pt1_r >= last) ? 16'h0000 : pt1_r + 16'h0001;
      else pt1_nxt = pt1_r;
      if (!run2) pt2_nxt = 16'h0000;
      else if (tick2) pt2_nxt = (pt2_r >= last) ? 16'h0000 : pt2_r + 16'h0001;
      else pt2_nxt = pt2_r;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         shot1_r <= 1'b0;
         shot2_r <= 1'b0;
         pt1_r   <= 16'h0000;
         pt2_r   <= 16'h0000;
      end else begin
         shot1_r <= shot1_nxt;
         shot2_r <= shot2_nxt;
         pt1_r   <= pt1_nxt;
         pt2_r   <= pt2_nxt;
      end
   end

   // Common feed: second pair point is first pair point shifted
   logic signed [17:0] sh;
   logic [15:0]        pt2_eff;
   always_comb begin
      sh = $signed({2'b00, pt1_r}) + $signed({{2{xoff_r[15]}}, xoff_r});
      if (sh < 0) sh = sh + $signed({2'b00, len_r});     // R15
      else if (sh >= $signed({2'b00, len_r})) sh = sh - $signed({2'b00, len_r});
      pt2_eff = common ? sh[15:0] : pt2_r;
   end

   // ======================================================================
   // Marker generator
   // ======================================================================
   logic        mk_run, mk_tick, mk_raw, mk_r, mk_nxt;
   logic [15:0] mk_pt;
   logic [20:0] pstart, pt_ext;

   always_comb begin
      mk_run  = ctrl_r[SMCF_B_MK_SRC] ? (common ? run1 : run2) : run1; // R06
      mk_tick = ctrl_r[SMCF_B_MK_SRC] ? tick2 : tick1;
      mk_pt   = ctrl_r[SMCF_B_MK_SRC] ? pt2_eff : pt1_r;              // R06
      pstart  = {mpos_r, 5'h00};                                      // R09
      pt_ext  = {5'h00, mk_pt};
      if (!ctrl_r[SMCF_B_MK_SHP]) begin
         mk_raw = mk_run && pt_ext >= pstart                          // R22
                  && pt_ext < pstart + 21'(SMCF_PULSE_PTS);           // R07
      end else begin
         // Closing points of each waveform, never movable
         mk_raw = mk_run && {5'h00, mk_pt} + 21'(SMCF_WC_PTS)
                  >= {5'h00, len_r};                                  // R08
      end
      mk_nxt = ctrl_r[SMCF_B_MK_EN] & mk_raw;                         // R05
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mk_r <= 1'b0;                                                // R04
      end else begin
         mk_r <= mk_nxt;
      end
   end

   assign marker_out = mk_r;
   assign marker_led = ctrl_r[SMCF_B_MK_EN];                          // R05
   assign pair1_run  = run1;
   assign pair2_run  = run2;

   // ======================================================================
   // Register read-back
   // ======================================================================
   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == SMCF_CTRL_OFF) begin
         prdata = ctrl_r;
      end else if (paddr == SMCF_LEN_OFF) begin
         prdata = {16'h0000, len_r};
      end else if (paddr == SMCF_MPOS_OFF) begin
         prdata = {16'h0000, mpos_r};
      end else if (paddr == SMCF_XOFF_OFF) begin
         prdata = {{16{xoff_r[15]}}, xoff_r};
      end else if (paddr == SMCF_EXTF_OFF) begin
         prdata = extf_r;
      end else if (paddr == SMCF_STAT_OFF) begin
         prdata = {28'h0000000, mk_r, btn_r, run2, run1};
      end else if (paddr == SMCF_PT_OFF) begin
         prdata = {pt2_eff, pt1_r};
      end else begin
         pslverr = psel & penable;
      end
   end

   // ======================================================================
   // Checks
   // ======================================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence press_s;
      btn_press && btn_ok && mode1 == SMCF_TRIG;
   endsequence
   sequence start_s;
      ##1 shot1_r;
   endsequence

   marker_off_a: assert property (!ctrl_r[SMCF_B_MK_EN] |=> !marker_out) // R05
      else $error("marker active while switched off");
   btn_ignore_a: assert property ((!btn_ok && mode1 == SMCF_GATE)   // R01
      |-> !pair1_run)
      else $error("gate opened without external source");
   trig_start_a: assert property (press_s |-> start_s)                // R02
      else $error("press did not start a waveform");
   gate_stop_a: assert property ((mode1 == SMCF_GATE && !btn_r)      // R03
      |-> !pair1_run)
      else $error("gated run continued after release");
   pulse_head_a: assert property ((ctrl_r[SMCF_B_MK_EN] && !ctrl_r[2]  // R10
      && !ctrl_r[1] && mpos_r == 16'h0000 && run1 && pt1_r == 16'h0000)
      |=> marker_out)
      else $error("pulse missing at first point");
   pulse_len_a: assert property ((!ctrl_r[SMCF_B_MK_SHP] && mk_raw) // R07
      |-> mk_pt - mpos_r * 16'(SMCF_POS_STEP) < 16'(SMCF_PULSE_PTS))
      else $error("pulse wider than sixteen points");
   ext_gate_a: assert property (!ctrl_r[SMCF_B_FN_ARB]             // R16
      |-> !ctrl_r[SMCF_B_P1_EXT] && !ctrl_r[SMCF_B_P2_EXT])
      else $error("external clock outside arbitrary mode");
   xoff_lock_a: assert property (!common |=> $stable(xoff_r))        // R14
      else $error("offset changed in separate feed");
   common_tick_a: assert property (common |-> tick2 == tick1)         // R11
      else $error("common pairs on different ticks");
   extf_lock_a: assert property ((!ctrl_r[8] && !ctrl_r[9])          // R17
      |=> $stable(extf_r))
      else $error("frequency setting changed while inactive");

endmodule : smcf_top
`default_nettype wire

// >>> verif/smcf_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Front-panel operator and external sample clock source
module smcf_partner #(
   parameter int HALF = 5
) (
   input  wire logic mclk,
   input  wire logic push,
   input  wire logic ext_on,
   output logic      manual_push_button,
   output logic      ext_sample_clock
);
   int cnt;

   initial begin
      cnt = 0;
      manual_push_button = 1'b0;
      ext_sample_clock = 1'b0;
   end

   // Button is an async pin: it moves off the clock edge
   always @(push) begin
      manual_push_button <= #3 push;
   end

   // Clock stands low while switched off, as a silent source would
   always @(negedge mclk) begin
      if (ext_on !== 1'b1) begin
         cnt <= 0;
         ext_sample_clock <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         ext_sample_clock <= ~ext_sample_clock;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : smcf_partner
`default_nettype wire

// >>> verif/smcf_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module smcf_top_bench;
   import smcf_pkg::*;
   localparam int          T   = 10;
   localparam logic [31:0] MK  = 32'h1 << SMCF_B_MK_EN;
   localparam logic [31:0] SRC = 32'h1 << SMCF_B_MK_SRC;
   localparam logic [31:0] SHP = 32'h1 << SMCF_B_MK_SHP;
   localparam logic [31:0] COM = 32'h1 << SMCF_B_COMMON;
   localparam logic [31:0] TRG = 32'h1 << SMCF_B_TRG_EXT;
   localparam logic [31:0] FN  = 32'h1 << SMCF_B_FN_ARB;
   localparam logic [31:0] P1  = 32'h1 << SMCF_B_P1_EXT;
   localparam logic [31:0] P2  = 32'h1 << SMCF_B_P2_EXT;
   localparam logic [31:0] TR1 = 32'(SMCF_TRIG) << SMCF_B_RUN1;
   localparam logic [31:0] GT1 = 32'(SMCF_GATE) << SMCF_B_RUN1;
   localparam logic [31:0] TR2 = 32'(SMCF_TRIG) << SMCF_B_RUN2;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        push, ext_on, btn, sclk;
   logic        marker_out, marker_led, pair1_run, pair2_run;
   int          miscompares, n_checks, base, r0, m0, mk_w, run_w, run2_w;
   int          ex[3] = '{0, 2, 8};

   smcf_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .manual_push_button(btn),
      .ext_sample_clock(sclk), .marker_out(marker_out),
      .marker_led(marker_led), .pair1_run(pair1_run),
      .pair2_run(pair2_run));
   smcf_partner #(.HALF(T / 2)) op (.mclk(mclk), .push(push),
      .ext_on(ext_on), .manual_push_button(btn), .ext_sample_clock(sclk));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ============================================================
   // Access and checking tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
            exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Waits for the slave; only the watchdog ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask : rchk

   // Press for hold cycles; record run and marker timing in a window
   task automatic run(input int hold, input int win);
      r0 = -1;
      m0 = -1;
      mk_w = 0;
      run_w = 0;
      run2_w = 0;
      @(posedge mclk);
      push <= 1'b1;
      for (int c = 0; c < win; c++) begin
         @(posedge mclk);
         // Button held for exactly hold cycles
         if (c + 1 == hold) push <= 1'b0;
         #1;
         if (pair1_run === 1'b1) begin
            if (r0 < 0) r0 = c;
            run_w++;
         end
         if (pair2_run === 1'b1) run2_w++;
         if (marker_out === 1'b1) begin
            if (m0 < 0) m0 = c;
            mk_w++;
         end
      end
   endtask : run

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // Whole run is near 13k cycles; this bound is generous
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      give_verdict();
   end

   // ============================================================
   // Tests
   initial begin
      miscompares = 0;
      n_checks = 0;
      {psel, penable, pwrite, push, ext_on} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst = 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(marker_out, 1'b0);
      chk(marker_led, 1'b0);
      rchk(SMCF_CTRL_OFF, 32'hFFFFFFFF, 32'h0);
      rchk(SMCF_LEN_OFF, 32'hFFFF, 32'h40);
      rchk(SMCF_MPOS_OFF, 32'hFFFF, 32'h0);
      rchk(SMCF_XOFF_OFF, 32'hFFFF, 32'h0);
      rchk(SMCF_EXTF_OFF, 32'hFFFFFFFF, 32'h0);
      rchk(8'h1C, 32'hFFFFFFFF, 32'h0);
      chk(err, 1'b1);
      wr(SMCF_CTRL_OFF, MK | TR1);
      run(6, 150);
      chk(run_w, 0);
      wr(SMCF_CTRL_OFF, MK | TRG | TR1);
      #1;
      chk(marker_led, 1'b1);
      run(100, 200);
      chk(run_w, 64);
      chk(mk_w, 16);
      base = m0 - r0;
      wr(SMCF_MPOS_OFF, 32'h1);
      run(6, 150);
      chk(m0 - r0, base + 32);
      chk(mk_w, 16);
      wr(SMCF_CTRL_OFF, MK | SHP | TRG | TR1);
      run(6, 150);
      chk(m0 - r0, base + 48);
      chk(mk_w, 16);
      wr(SMCF_CTRL_OFF, TRG | TR1);
      run(6, 150);
      chk(mk_w, 0);
      chk(marker_led, 1'b0);
      wr(SMCF_CTRL_OFF, TRG | GT1);
      run(40, 100);
      chk(run_w, 40);
      wr(SMCF_XOFF_OFF, 32'h20);
      rchk(SMCF_XOFF_OFF, 32'hFFFF, 32'h0);
      wr(SMCF_MPOS_OFF, 32'h0);
      wr(SMCF_CTRL_OFF, MK | SRC | COM | TRG | TR1);
      wr(SMCF_XOFF_OFF, 32'h20);
      rchk(SMCF_XOFF_OFF, 32'hFFFF, 32'h20);
      wr(SMCF_XOFF_OFF, 32'h40);
      rchk(SMCF_XOFF_OFF, 32'hFFFF, 32'h20);
      run(6, 150);
      chk(run2_w, 64);
      chk(m0 - r0, base + 32);
      wr(SMCF_XOFF_OFF, 32'hFFF0);
      rchk(SMCF_XOFF_OFF, 32'hFFFF, 32'hFFF0);
      run(6, 150);
      chk(m0 - r0, base + 16);
      wr(SMCF_CTRL_OFF, MK | SRC | COM | TRG | TR1 | FN | P2);
      rchk(SMCF_CTRL_OFF, P2, 32'h0);
      wr(SMCF_CTRL_OFF, P1);
      rchk(SMCF_CTRL_OFF, P1, 32'h0);
      wr(SMCF_EXTF_OFF, 32'h1234);
      rchk(SMCF_EXTF_OFF, 32'hFFFFFFFF, 32'h0);
      wr(SMCF_CTRL_OFF, FN | P1 | P2);
      rchk(SMCF_CTRL_OFF, P1 | P2, P1 | P2);
      wr(SMCF_EXTF_OFF, 32'h1234);
      rchk(SMCF_EXTF_OFF, 32'hFFFFFFFF, 32'h1234);
      wr(SMCF_CTRL_OFF, FN | P2 | (32'h9 << SMCF_B_DIV));
      rchk(SMCF_CTRL_OFF, P1 | P2, P2);
      rchk(SMCF_CTRL_OFF, 32'hF000, 32'(SMCF_DIV_MAX) << SMCF_B_DIV);
      // Short waveform keeps the divide-by-256 run affordable
      wr(SMCF_LEN_OFF, 32'h4);
      ext_on <= 1'b1;
      foreach (ex[i]) begin
         wr(SMCF_CTRL_OFF, FN | P1 | P2 | TRG | TR1 | TR2
            | (32'(ex[i]) << SMCF_B_DIV));
         run(6, ((4 * T) << ex[i]) + 300);
         // First tick lands anywhere in the first period: width in
         // (3P, 4P], so rounding up gives exactly the point count
         chk((run_w + (T << ex[i]) - 1) / (T << ex[i]), 4);
         chk((run2_w + T - 1) / T, 4);
      end
      give_verdict();
   end
endmodule : smcf_top_bench
`default_nettype wire
